// File: rf_receive_status_params.svh
// Register offsets, field positions and reset values of the receive status bank
`ifndef RF_RECEIVE_STATUS_PARAMS_SVH
`define RF_RECEIVE_STATUS_PARAMS_SVH
`define ADDR_RECEIVE_ERROR_FLAGS     8'h0a
`define ADDR_TRANSCEIVER_STATE       8'h0b
`define ADDR_RECEIVE_BIT_ALIGNMENT   8'h0c
`define ADDR_COLLISION_POSITION      8'h0d
`define BIT_NVM_ERROR                7
`define BIT_FIFO_WRITE_ERROR         6
`define BIT_FIFO_OVERFLOW            5
`define BIT_SHORT_FRAME              4
`define BIT_EMPTY_TX                 3
`define BIT_COLLISION_SEEN           2
`define BIT_PROTOCOL_ERROR           1
`define BIT_INTEGRITY_ERROR          0
`define BIT_CIPHER_ACTIVE            5
`define BIT_KEEP_BITS_POST_COLL      7
`define BIT_COLL_AS_INTEGRITY        3
`define RESET_BYTE                   8'h00
`define MIN_FRAME_BITS               4
`define EMD_MIN_FRAME_BYTES          3
`define COLL_INDEX_LIMIT             64
`endif

// File: rf_receive_status_pkg.sv
// Types shared by the receive status bank
package rf_receive_status_pkg;
	typedef enum logic [2:0] {
		ST_IDLE         = 3'h0,
		ST_TRANSMIT_WAIT= 3'h1,
		ST_TRANSMITTING = 3'h3,
		ST_RECEIVE_WAIT = 3'h5,
		ST_WAIT_DATA    = 3'h6,
		ST_RECEIVING    = 3'h7
	} transceiver_state_t;
endpackage

// File: collision_tracker.sv
// First-collision index capture with alignment offset
`timescale 1ns/10ps
`include "rf_receive_status_params.svh"
module collision_tracker (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Control
	input  wire logic       rx_start,
	input  wire logic [2:0] bit_offset,
	// Decoder bit stream
	input  wire logic       bit_valid,
	input  wire logic       bit_collided,
	input  wire logic       in_eof,
	// Result
	output logic            collision_index_valid,
	output logic [6:0]      collision_index,
	output logic            first_collision
);
	logic [9:0] bit_count;
	logic       seen;
	wire  [9:0] position = bit_count + {7'h00, bit_offset};
	wire        hit      = bit_valid && bit_collided && !in_eof && !seen;
	wire        in_range = position < 10'(`COLL_INDEX_LIMIT);
	assign first_collision = hit;

	// Count data bits and latch the first collided one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			bit_count             <= 10'h000;
			seen                  <= 1'b0;
			collision_index_valid <= 1'b0;
			collision_index       <= 7'h00;
		end else if (rx_start) begin
			bit_count             <= 10'h000;
			seen                  <= 1'b0;
			collision_index_valid <= 1'b0;
			collision_index       <= 7'h00;
		end else if (bit_valid) begin
			if (bit_count != 10'h3ff)
				bit_count <= bit_count + 10'h001;
			if (hit) begin
				seen                  <= 1'b1;
				collision_index_valid <= in_range;
				collision_index       <= in_range ? position[6:0] : 7'h00;
			end
		end
	end
endmodule

// File: rf_receive_status_regs.sv
// Error, state, bit alignment and collision registers of the contactless transceiver
`timescale 1ns/10ps
`include "rf_receive_status_params.svh"
// How it works
// - FIFO write during CRC, receive phases or authentication sets write error; command start clears.
// - In multi-frame receive, write error clears only after error flags stored.
// - Write to full FIFO sets overflow; later writes are discarded.
// - Valid start of frame followed by fewer than four bits sets short-frame error.
// - Short frames dropped, no receive-done, decoder stays on; EMD uses three bytes.
// - Receive-side errors clear at receive start or at wait-for-data in transceive.
// - Transmission required with empty FIFO sets empty-transmit error.
// - Collision sets flag and records first position, except inside end-of-frame.
// - Protocol faults set protocol error, stop reception, drop last byte.
// - Parity or CRC mismatch sets integrity error; reception continues.
// - Collision-as-integrity bit makes collisions also set integrity error.
// - Top error bit shows last nonvolatile memory command failed.
// - Cipher bit set only by authentication; host clearing switches cipher off.
// - Three-bit state field uses the fixed transceiver state encoding.
// - Without keep-bits, every bit after a collision is stored as zero.
// - Alignment field places first received bit; zero means byte-oriented.
// - Last-bits field written at end of bit-oriented reception, reset at start.
// - Seven-bit collision index, zero first, only within first eight bytes.
// - Index valid only when a reportable collision happened.
// - Nonzero alignment adds its offset into the collision index.
module rf_receive_status_regs
	import rf_receive_status_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Host register port
	input  wire logic       reg_write,
	input  wire logic       reg_read,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic [7:0]      reg_rdata,
	// FIFO host side
	input  wire logic       fifo_host_write,
	input  wire logic       fifo_full,
	output logic            fifo_write_accept,
	// Command sequencer
	input  wire logic       command_start,
	input  wire logic       receive_command_start,
	input  wire logic       card_authenticate_command,
	input  wire logic       authenticate_success,
	input  wire logic       multi_frame_receive,
	input  wire logic       error_flags_stored,
	input  wire logic       crc_sending,
	input  wire logic       transmit_request,
	input  wire logic       fifo_empty,
	input  wire logic [2:0] next_state_code,
	input  wire logic       nvm_command_done,
	input  wire logic       nvm_command_failed,
	input  wire logic       emd_suppression,
	// Receive decoder
	input  wire logic       sof_seen,
	input  wire logic       rx_bit_valid,
	input  wire logic       rx_bit,
	input  wire logic       rx_bit_collided,
	input  wire logic       rx_in_eof,
	input  wire logic       rx_byte_done,
	input  wire logic       frame_end,
	input  wire logic       protocol_fault,
	input  wire logic       integrity_fault,
	// Results toward the datapath
	output logic            cipher_active,
	output logic            stored_bit,
	output logic            rx_stop,
	output logic            byte_store,
	output logic            receive_done_interrupt,
	output logic            receive_decoder_enable
);
	transceiver_state_t state;
	logic [7:0] err;
	logic       keep_bits_post_collision;
	logic [2:0] receive_bit_offset;
	logic       collision_as_integrity;
	logic [2:0] final_byte_valid_bits;
	logic       coll_since_start;
	logic [9:0] frame_bits;
	logic       frame_open;
	logic       coll_valid;
	logic [6:0] coll_index;
	logic       first_coll;

	// Address decode
	wire sel_err   = (reg_addr == `ADDR_RECEIVE_ERROR_FLAGS);
	wire sel_state = (reg_addr == `ADDR_TRANSCEIVER_STATE);
	wire sel_align = (reg_addr == `ADDR_RECEIVE_BIT_ALIGNMENT);
	wire sel_coll  = (reg_addr == `ADDR_COLLISION_POSITION);
	wire wr_state  = reg_write && sel_state;
	wire wr_align  = reg_write && sel_align;

	// Phase decode from the sequencer's state
	wire next_rx_phase = (next_state_code == 3'(ST_RECEIVE_WAIT)) || (next_state_code == 3'(ST_WAIT_DATA)) ||
		(next_state_code == 3'(ST_RECEIVING));
	wire rx_phase      = (state == ST_RECEIVE_WAIT) || (state == ST_WAIT_DATA) || (state == ST_RECEIVING);
	wire enter_wait    = (next_state_code == 3'(ST_WAIT_DATA)) && (state != ST_WAIT_DATA);
	wire rx_clear      = receive_command_start || enter_wait;
	wire bad_fifo_wr   = fifo_host_write && (crc_sending || rx_phase || card_authenticate_command);
	wire over_wr       = fifo_host_write && (fifo_full || err[`BIT_FIFO_OVERFLOW]);
	// Clear of the write error: immediate, or deferred in multi-frame mode
	wire wr_err_clear  = multi_frame_receive ? error_flags_stored : command_start;
	wire coll_event    = first_coll;
	wire any_coll      = rx_bit_valid && rx_bit_collided && !rx_in_eof;
	// Short frame: fewer than four bits, or under three bytes with EMD on
	wire [9:0] short_limit = emd_suppression ? 10'(`EMD_MIN_FRAME_BYTES * 8) : 10'(`MIN_FRAME_BITS);
	wire too_few_bits  = frame_bits < 10'(`MIN_FRAME_BITS);
	wire short_frame   = frame_open && frame_end && (frame_bits < short_limit);
	wire [2:0] bits_mod = frame_bits[2:0] + receive_bit_offset;

	// Next values of the error flags; a set always wins over a clear
	logic [7:0] next_err;
	always_comb begin
		next_err = err;
		if (nvm_command_done)
			next_err[`BIT_NVM_ERROR] = nvm_command_failed;
		if (wr_err_clear)
			next_err[`BIT_FIFO_WRITE_ERROR] = 1'b0;
		if (command_start)
			next_err[`BIT_FIFO_OVERFLOW] = 1'b0;
		if (command_start)
			next_err[`BIT_EMPTY_TX] = 1'b0;
		if (rx_clear) begin
			next_err[`BIT_SHORT_FRAME]     = 1'b0;
			next_err[`BIT_COLLISION_SEEN]  = 1'b0;
			next_err[`BIT_PROTOCOL_ERROR]  = 1'b0;
			next_err[`BIT_INTEGRITY_ERROR] = 1'b0;
		end
		if (bad_fifo_wr)
			next_err[`BIT_FIFO_WRITE_ERROR] = 1'b1;
		if (fifo_host_write && fifo_full)
			next_err[`BIT_FIFO_OVERFLOW] = 1'b1;
		if (frame_open && frame_end && too_few_bits)
			next_err[`BIT_SHORT_FRAME] = 1'b1;
		if (transmit_request && fifo_empty)
			next_err[`BIT_EMPTY_TX] = 1'b1;
		if (coll_event)
			next_err[`BIT_COLLISION_SEEN] = 1'b1;
		if (protocol_fault)
			next_err[`BIT_PROTOCOL_ERROR] = 1'b1;
		if (integrity_fault || (collision_as_integrity && any_coll))
			next_err[`BIT_INTEGRITY_ERROR] = 1'b1;
	end

	// Error register; host writes are ignored since every bit is read-only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			err <= `RESET_BYTE;
		else
			err <= next_err;
	end

	// State field mirror of the sequencer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			state <= ST_IDLE;
		else
			state <= transceiver_state_t'(next_state_code);
	end

	// Cipher: only authentication sets, host may only clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			cipher_active <= 1'b0;
		else if (card_authenticate_command && authenticate_success)
			cipher_active <= 1'b1;
		else if (wr_state && !reg_wdata[`BIT_CIPHER_ACTIVE])
			cipher_active <= 1'b0;
	end

	// Host-written alignment controls
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			keep_bits_post_collision <= 1'b0;
			receive_bit_offset       <= 3'h0;
			collision_as_integrity   <= 1'b0;
		end else if (wr_align) begin
			keep_bits_post_collision <= reg_wdata[`BIT_KEEP_BITS_POST_COLL];
			receive_bit_offset       <= reg_wdata[6:4];
			collision_as_integrity   <= reg_wdata[`BIT_COLL_AS_INTEGRITY];
		end
	end

	// Last-bits field: cleared at reception start, set at bit-oriented frame end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			final_byte_valid_bits <= 3'h0;
		else if (rx_clear || sof_seen)
			final_byte_valid_bits <= 3'h0;
		else if (frame_open && frame_end && receive_bit_offset != 3'h0)
			final_byte_valid_bits <= bits_mod;
	end

	// Frame bit counter and post-collision tracking
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			frame_bits       <= 10'h000;
			frame_open       <= 1'b0;
			coll_since_start <= 1'b0;
		end else if (sof_seen) begin
			frame_bits       <= 10'h000;
			frame_open       <= 1'b1;
			coll_since_start <= 1'b0;
		end else begin
			if (frame_end || protocol_fault)
				frame_open <= 1'b0;
			if (rx_bit_valid && frame_bits != 10'h3ff)
				frame_bits <= frame_bits + 10'h001;
			if (any_coll)
				coll_since_start <= 1'b1;
		end
	end

	// Datapath strobes, all registered
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stored_bit             <= 1'b0;
			rx_stop                <= 1'b0;
			byte_store             <= 1'b0;
			receive_done_interrupt <= 1'b0;
			receive_decoder_enable <= 1'b0;
			fifo_write_accept      <= 1'b0;
		end else begin
			stored_bit             <= (coll_since_start || any_coll) && !keep_bits_post_collision ? 1'b0 : rx_bit;
			rx_stop                <= protocol_fault;
			byte_store             <= rx_byte_done && !protocol_fault;
			receive_done_interrupt <= frame_open && frame_end && !short_frame;
			receive_decoder_enable <= next_rx_phase && !(protocol_fault || (frame_end && !short_frame));
			fifo_write_accept      <= fifo_host_write && !over_wr;
		end
	end

	// First collision position
	collision_tracker u_collision (
		.clk                   (clk),
		.rst_b                 (rst_b),
		.rx_start              (rx_clear),
		.bit_offset            (receive_bit_offset),
		.bit_valid             (rx_bit_valid),
		.bit_collided          (rx_bit_collided),
		.in_eof                (rx_in_eof),
		.collision_index_valid (coll_valid),
		.collision_index       (coll_index),
		.first_collision       (first_coll)
	);

	// Read data, registered; unmapped addresses read zero
	wire [7:0] rd_err   = err;
	wire [7:0] rd_state = {2'b00, cipher_active, 2'b00, state};
	wire [7:0] rd_align = {keep_bits_post_collision, receive_bit_offset, collision_as_integrity, final_byte_valid_bits};
	wire [7:0] rd_coll  = {coll_valid, coll_index};
	wire [7:0] rd_mux   = sel_err ? rd_err : sel_state ? rd_state : sel_align ? rd_align : sel_coll ? rd_coll : 8'h00;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= `RESET_BYTE;
		else if (reg_read)
			reg_rdata <= rd_mux;
	end
endmodule

// File: rf_receive_status_chk.sv
// Port-level checker for the receive status register bank
`timescale 1ns/10ps
module rf_receive_status_chk (
	// Clock and reset
	input wire logic       clk,
	input wire logic       rst_b,
	// Observed ports
	input wire logic       reg_write,
	input wire logic       reg_read,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       fifo_host_write,
	input wire logic       fifo_full,
	input wire logic       fifo_write_accept,
	input wire logic       authenticate_success,
	input wire logic       crc_sending,
	input wire logic [2:0] next_state_code,
	input wire logic       nvm_command_done,
	input wire logic       nvm_command_failed,
	input wire logic       protocol_fault,
	input wire logic       cipher_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Host reads of the error and state registers
	sequence rd_err;
		reg_read && reg_addr == 8'h0a;
	endsequence
	sequence rd_state;
		reg_read && reg_addr == 8'h0b;
	endsequence
	full_refused_a: assert property (fifo_host_write && fifo_full |=> !fifo_write_accept)
		else $error("write into full fifo accepted");
	state_field_a: assert property (rd_state |=> reg_rdata[2:0] == $past(next_state_code, 2))
		else $error("state field differs from sequencer state");
	unmapped_zero_a: assert property (reg_read && (reg_addr < 8'h0a || reg_addr > 8'h0d) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	cipher_set_a: assert property ($rose(cipher_active) |-> $past(authenticate_success))
		else $error("cipher rose without authentication");
	cipher_clear_a: assert property (reg_write && reg_addr == 8'h0b && !reg_wdata[5] && !authenticate_success
		|=> !cipher_active)
		else $error("cipher stayed on after host clear");
	nvm_flag_a: assert property (nvm_command_done && nvm_command_failed ##1 rd_err |=> reg_rdata[7])
		else $error("nvm error flag missing");
	write_err_a: assert property (fifo_host_write && crc_sending ##1 rd_err |=> reg_rdata[6])
		else $error("fifo write error flag missing");
	prot_flag_a: assert property (protocol_fault ##1 rd_err |=> reg_rdata[1])
		else $error("protocol error flag missing");
endmodule
bind rf_receive_status_regs rf_receive_status_chk u_chk (.clk(clk), .rst_b(rst_b), .reg_write(reg_write),
	.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.fifo_host_write(fifo_host_write), .fifo_full(fifo_full), .fifo_write_accept(fifo_write_accept),
	.authenticate_success(authenticate_success), .crc_sending(crc_sending), .next_state_code(next_state_code),
	.nvm_command_done(nvm_command_done), .nvm_command_failed(nvm_command_failed),
	.protocol_fault(protocol_fault), .cipher_active(cipher_active));

// File: card_frame_model.sv
// Behavioural card sending frames toward the receive decoder
`timescale 1ns/10ps
module card_frame_model (
	// Clock
	input wire logic clk,
	// Decoder side
	output logic     sof_seen,
	output logic     rx_bit_valid,
	output logic     rx_bit,
	output logic     rx_bit_collided,
	output logic     rx_in_eof,
	output logic     frame_end
);
	// Quiet air at start
	initial begin
		{sof_seen, rx_bit_valid, rx_bit, rx_bit_collided, rx_in_eof, frame_end} = 6'h00;
	end
	// One bit every other cycle; between bits the data line inverts so a stale bit never looks valid
	task automatic send(input int nbits, input int coll);
		@(negedge clk) sof_seen = 1'b1;
		@(negedge clk) sof_seen = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			rx_bit_valid = 1'b1;
			rx_bit = i[0];
			rx_bit_collided = (i == coll);
			@(negedge clk) rx_bit_valid = 1'b0;
			rx_bit_collided = 1'b0;
			rx_bit = ~rx_bit;
			@(negedge clk);
		end
		frame_end = 1'b1;
		@(negedge clk) frame_end = 1'b0;
	endtask
endmodule

// File: rf_receive_status_regs_test.sv
// Self-checking bench of the receive status register bank
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module rf_receive_status_regs_test;
	import rf_receive_status_pkg::*;
	typedef struct {logic [2:0] code; logic [7:0] exp;} row_t;
	logic       clk = 1'b0, rst_b = 1'b0, reg_write = 1'b0, reg_read = 1'b0, tie0 = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, ev = 8'h00;
	logic       fifo_full = 1'b0, auth_cmd = 1'b0, crc_sending = 1'b0, fifo_empty = 1'b0, nvm_failed = 1'b0;
	logic [2:0] next_state_code = 3'h0;
	wire  [7:0] reg_rdata;
	wire        accept, cipher_active, stored_bit, rx_stop, byte_store, done_irq, dec_en;
	wire        sof, bvalid, bit_v, bcoll, beof, fend;
	int         failures = 0, comparisons = 0, dones = 0;
	row_t       rows [6] = '{'{3'h0, 8'h00}, '{3'h1, 8'h01}, '{3'h3, 8'h03}, '{3'h5, 8'h05}, '{3'h6, 8'h06},
		'{3'h7, 8'h07}};
	card_frame_model u_card (.clk(clk), .sof_seen(sof), .rx_bit_valid(bvalid), .rx_bit(bit_v),
		.rx_bit_collided(bcoll), .rx_in_eof(beof), .frame_end(fend));
	// Event strobes packed one bit each into a byte so one task pulses any mix of them
	rf_receive_status_regs u_rf_receive_status_regs (.clk(clk), .rst_b(rst_b), .reg_write(reg_write),
		.reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.fifo_host_write(ev[5]), .fifo_full(fifo_full), .fifo_write_accept(accept), .command_start(ev[0]),
		.receive_command_start(ev[1]), .card_authenticate_command(auth_cmd), .authenticate_success(ev[2]),
		.multi_frame_receive(tie0), .error_flags_stored(tie0), .crc_sending(crc_sending),
		.transmit_request(ev[3]), .fifo_empty(fifo_empty), .next_state_code(next_state_code),
		.nvm_command_done(ev[4]), .nvm_command_failed(nvm_failed), .emd_suppression(tie0), .sof_seen(sof),
		.rx_bit_valid(bvalid), .rx_bit(bit_v), .rx_bit_collided(bcoll), .rx_in_eof(beof),
		.rx_byte_done(tie0), .frame_end(fend), .protocol_fault(ev[6]), .integrity_fault(ev[7]),
		.cipher_active(cipher_active), .stored_bit(stored_bit), .rx_stop(rx_stop), .byte_store(byte_store),
		.receive_done_interrupt(done_irq), .receive_decoder_enable(dec_en));
	// Clock, 20 ns period
	initial begin
		forever #10 clk = ~clk;
	end
	// Receive-done pulses seen so far
	always @(posedge clk) if (done_irq === 1'b1) dones++;
	task automatic pulse(input logic [7:0] v);
		@(negedge clk) ev = v;
		@(negedge clk) ev = 8'h00;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk) reg_write = 1'b0;
	endtask
	// Data lands on the edge after the strobe, so the next falling edge sees it settled
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk) {reg_read, reg_addr} = {1'b1, a};
		@(negedge clk) reg_read = 1'b0;
		`CHK(reg_rdata, e)
	endtask
	task automatic final_report();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#100us failures++;
		final_report();
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		for (int a = 10; a < 14; a++) rd(a[7:0], 8'h00);
		rd(8'h20, 8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			next_state_code = rows[i].code;
			rd(8'h0b, rows[i].exp);
		end
		next_state_code = 3'h0;
		$display("test state rows done");
		wr(8'h0a, 8'hff);
		rd(8'h0a, 8'h00);
		wr(8'h0c, 8'hff);
		rd(8'h0c, 8'hf8);
		wr(8'h0c, 8'h00);
		pulse(8'h20);
		`CHK(accept, 1'b1)
		crc_sending = 1'b1;
		pulse(8'h20);
		crc_sending = 1'b0;
		rd(8'h0a, 8'h40);
		pulse(8'h01);
		rd(8'h0a, 8'h00);
		fifo_full = 1'b1;
		pulse(8'h20);
		`CHK(accept, 1'b0)
		fifo_full = 1'b0;
		pulse(8'h20);
		`CHK(accept, 1'b0)
		rd(8'h0a, 8'h20);
		fifo_empty = 1'b1;
		pulse(8'h09);
		fifo_empty = 1'b0;
		rd(8'h0a, 8'h08);
		nvm_failed = 1'b1;
		pulse(8'h10);
		rd(8'h0a, 8'h88);
		nvm_failed = 1'b0;
		pulse(8'h10);
		rd(8'h0a, 8'h08);
		auth_cmd = 1'b1;
		pulse(8'h04);
		rd(8'h0b, 8'h20);
		wr(8'h0b, 8'h00);
		rd(8'h0b, 8'h00);
		$display("test flags done");
		pulse(8'h03);
		u_card.send(2, -1);
		rd(8'h0a, 8'h10);
		`CHK(dones, 0)
		u_card.send(8, -1);
		// The receive-done pulse is counted one edge after it is launched
		@(negedge clk);
		`CHK(dones, 1)
		`CHK(dec_en, 1'b0)
		pulse(8'h02);
		rd(8'h0a, 8'h00);
		u_card.send(10, 3);
		rd(8'h0a, 8'h04);
		rd(8'h0d, 8'h83);
		wr(8'h0c, 8'h48);
		pulse(8'h02);
		u_card.send(8, 3);
		rd(8'h0d, 8'h87);
		rd(8'h0a, 8'h05);
		rd(8'h0c, 8'h4c);
		pulse(8'h02);
		pulse(8'h80);
		rd(8'h0a, 8'h01);
		pulse(8'h40);
		`CHK(rx_stop, 1'b1)
		`CHK(byte_store, 1'b0)
		rd(8'h0a, 8'h03);
		$display("test receive done");
		@(negedge clk) rst_b = 1'b0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		rd(8'h0a, 8'h00);
		rd(8'h0c, 8'h00);
		rd(8'h0d, 8'h00);
		$display("test second reset done");
		final_report();
	end
endmodule
